/* File: hdl/gacp_regs.vh */
// Constants of the gate array configuration port
`ifndef GACP_REGS_VH
`define GACP_REGS_VH

// ********************
// Mode codes {zero, one, two}
// ********************
`define GACP_MODE_MSTSER 3'h0
`define GACP_MODE_MSTLO  3'h1
`define GACP_MODE_MSTHI  3'h3
`define GACP_MODE_PER   3'h5
`define GACP_MODE_SLV   3'h7

// ********************
// Top level states
// ********************
`define GACP_ST_RESET   2'h0
`define GACP_ST_CONFIG  2'h1
`define GACP_ST_WAIT    2'h2
`define GACP_ST_USER    2'h3

// ********************
// Parallel fetch phases
// ********************
`define GACP_PH_ADDR    2'h0
`define GACP_PH_READ    2'h1
`define GACP_PH_SHIFT   2'h2

// ********************
// Addresses, sizes, timing
// ********************
`define GACP_ADDR_LOW   16'h0000
`define GACP_ADDR_HIGH  16'hFFFF
`define GACP_CFG_BITS   16'h0400
`define GACP_SNAP_W     16
`define GACP_CLK_NS     40
`define GACP_MCLK_HALF_NS 160
// Half period in system cycles, sized to fit the divider
`define GACP_MCLK_HALF_CYC 8'h04

`endif

/* File: hdl/gacp_sync3.v */
// Three stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module gacp_sync3 #(
  parameter W = 1
) (
  input  wire         clk_sys, // System clock
  input  wire         nrst,    // Async reset, active low
  input  wire [W-1:0] rawIn,   // Asynchronous inputs
  output wire [W-1:0] fltOut   // Filtered, synchronous levels
);

  reg  [W-1:0] stage1_ff;
  reg  [W-1:0] stage2_ff;
  reg  [W-1:0] stage3_ff;
  reg  [W-1:0] flt_ff;
  wire [W-1:0] agree;

  // Stage one feeds stage two only
  assign agree  = ~(stage2_ff ^ stage3_ff);
  assign fltOut = flt_ff;

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stage1_ff <= {W{1'b0}};
      stage2_ff <= {W{1'b0}};
      stage3_ff <= {W{1'b0}};
      flt_ff    <= {W{1'b0}};
    end else begin
      stage1_ff <= rawIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      flt_ff    <= (stage3_ff & agree) | (flt_ff & ~agree);
    end
  end

endmodule

`default_nettype wire

/* File: hdl/gacp_config_port.v */
// Configuration port of a programmable gate array
`timescale 1ns/1ps
`default_nettype none
`include "gacp_regs.vh"

// Operation
// - Slave, master serial: one bit per rising clock
// - Forward chain data on serial output
// - Clock pin driven except in slave mode, and only while loading
// - User mode: clock, trigger, data for readback
// - Read strobe low expecting data, high otherwise
// - Master serial: read strobe clocks PROM
// - High and low outputs held while configuring
// - Pull-ups on during configuration only
// - Peripheral selected: both lows low, high high
// - Write strobe rise captures one bit
// - Address, data buses only in parallel modes
// - Master low: start 0000, increment
// - Keep fetching while done line low
// - Master high: start FFFF, decrement
// - Mode 111 loads as serial shift chain
// - Release done line when fully loaded
// - Serial input shares data bit zero pin
// - Mode pins latched at reset release
// - Open-drain done; user mode once line high
module gacp_config_port (
  input  wire        clk_sys,                  // System clock, 25 MHz
  input  wire        nrst,                     // Power-on reset, active low
  input  wire        resetPinN,                // Device reset pin, active low
  input  wire        modeSelectZeroIn,         // Mode pin zero / readback trigger
  input  wire        modeSelectOneIn,          // Mode pin one, input side
  output wire        modeSelectOneOut,         // Readback data out
  output wire        modeSelectOneOe,          // Readback data enable
  input  wire        modeSelectTwoIn,          // Mode pin two
  input  wire        configurationClockIn,     // Clock pin, input side
  output wire        configurationClockOut,    // Clock pin, output side
  output wire        configurationClockOe,     // Clock pin enable
  input  wire [7:0]  promDataBus,              // PROM data; bit 0 is serial in
  output wire        serialDataOut,            // Daisy chain data out
  output wire        readStrobeN,              // Read strobe, low = data expected
  input  wire        writeStrobeN,             // Peripheral write strobe
  input  wire        chipSelectLowAN,          // Chip select, active low
  input  wire        chipSelectLowBN,          // Chip select, active low
  input  wire        chipSelectHigh,           // Chip select, active high
  input  wire        doneIn,                   // Wired done line level
  output wire        doneOut,                  // Done drive value (low)
  output wire        doneOe,                   // Done pull-down enable
  output wire        highWhileConfiguringOut,  // High during configuration
  output wire        highWhileConfiguringOe,   // Enable while configuring
  output wire        lowWhileConfiguringOut,   // Low during configuration
  output wire        lowWhileConfiguringOe,    // Enable while configuring
  output wire        pullUpEn,                 // Spare pin pull-ups enable
  output wire [15:0] promAddressBus,           // PROM address
  output wire        promAddressOe,            // PROM address enable
  output wire        userClear,                // User flip-flop clear
  output wire        userActive                // Functional operation
);

  localparam [7:0] HALF_CYC = `GACP_MCLK_HALF_CYC;

  // ********************
  // Input synchronisers
  // ********************
  wire        sRst;
  wire        sClk;
  wire        sDone;
  wire        sWr;
  wire        sCsA;
  wire        sCsB;
  wire        sCsH;
  wire        sModeZero;
  wire        sModeOne;
  wire        sModeTwo;
  wire [7:0]  sData;
  wire        sDin;

  gacp_sync3 #(
    .W (18)
  ) i_gacp_sync3 (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .rawIn   ({resetPinN, configurationClockIn, doneIn, writeStrobeN,
                chipSelectLowAN, chipSelectLowBN, chipSelectHigh,
                modeSelectZeroIn, modeSelectOneIn, modeSelectTwoIn,
                promDataBus}),
    .fltOut  ({sRst, sClk, sDone, sWr, sCsA, sCsB, sCsH,
               sModeZero, sModeOne, sModeTwo, sData})
  );

  assign sDin = sData[0];

  // ********************
  // State
  // ********************
  reg  [1:0]  state_ff;
  reg  [2:0]  mode_ff;
  reg  [15:0] bitCnt_ff;
  reg  [15:0] addr_ff;
  reg  [1:0]  phase_ff;
  reg  [7:0]  byte_ff;
  reg  [2:0]  bitIdx_ff;
  reg  [15:0] snap_ff;
  reg  [15:0] rbShift_ff;
  reg         rbOut_ff;
  reg         rbOe_ff;
  reg         dout_ff;
  reg         rdStrobe_ff;
  reg         doneOe_ff;
  reg         confOn_ff;
  reg         confOff_ff;
  reg         addrOe_ff;
  reg         clkOe_ff;
  reg         userClear_ff;
  reg         userActive_ff;
  reg         prevClk_ff;
  reg         prevWr_ff;
  reg         prevTrig_ff;
  reg         prevRst_ff;
  reg  [7:0]  divCnt_ff;
  reg         genClk_ff;
  reg         nxt_bitValid;
  reg         nxt_bitVal;
  reg  [2:0]  nxt_mode;

  wire inLoad   = (state_ff == `GACP_ST_CONFIG) || (state_ff == `GACP_ST_WAIT);
  wire isPar    = (mode_ff == `GACP_MODE_MSTLO) || (mode_ff == `GACP_MODE_MSTHI);
  wire clkRise  = sClk & ~prevClk_ff;
  wire wrRise   = sWr & ~prevWr_ff;
  wire trigRise = sModeZero & ~prevTrig_ff;
  wire rstRise  = sRst & ~prevRst_ff;
  wire selected = ~sCsA & ~sCsB & sCsH;
  wire runGen   = inLoad & (mode_ff != `GACP_MODE_SLV);
  wire divEnd   = (divCnt_ff == HALF_CYC - 8'h01);
  wire genRise  = runGen & divEnd & ~genClk_ff;
  wire lastBit  = (bitCnt_ff == `GACP_CFG_BITS - 16'h0001);

  // ********************
  // Internal timer for driven modes
  // ********************
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      divCnt_ff <= 8'h00;
      genClk_ff <= 1'b0;
    end else if (!runGen) begin
      divCnt_ff <= 8'h00;
      genClk_ff <= 1'b0;
    end else if (divEnd) begin
      divCnt_ff <= 8'h00;
      genClk_ff <= ~genClk_ff;
    end else begin
      divCnt_ff <= divCnt_ff + 8'h01;
    end
  end

  // ********************
  // Mode decode and bit source
  // ********************
  always @* begin
    case ({sModeZero, sModeOne, sModeTwo})
      `GACP_MODE_MSTSER: nxt_mode = `GACP_MODE_MSTSER;
      `GACP_MODE_MSTLO:  nxt_mode = `GACP_MODE_MSTLO;
      `GACP_MODE_MSTHI:  nxt_mode = `GACP_MODE_MSTHI;
      `GACP_MODE_PER: nxt_mode = `GACP_MODE_PER;
      default:        nxt_mode = `GACP_MODE_SLV;
    endcase
  end

  always @* begin
    nxt_bitValid = 1'b0;
    nxt_bitVal   = sDin;
    if (inLoad) begin
      case (mode_ff)
        `GACP_MODE_MSTSER: nxt_bitValid = genRise;
        `GACP_MODE_PER: nxt_bitValid = wrRise & selected;
        `GACP_MODE_MSTLO, `GACP_MODE_MSTHI: begin
          nxt_bitValid = genRise & (phase_ff == `GACP_PH_SHIFT);
          nxt_bitVal   = byte_ff[bitIdx_ff];
        end
        default: nxt_bitValid = clkRise;
      endcase
    end
  end

  // ********************
  // Sequencer
  // ********************
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_ff      <= `GACP_ST_RESET;
      mode_ff       <= `GACP_MODE_SLV;
      bitCnt_ff     <= 16'h0000;
      addr_ff       <= `GACP_ADDR_LOW;
      phase_ff      <= `GACP_PH_ADDR;
      byte_ff       <= 8'h00;
      bitIdx_ff     <= 3'h0;
      snap_ff       <= 16'h0000;
      rbShift_ff    <= 16'h0000;
      rbOut_ff      <= 1'b0;
      rbOe_ff       <= 1'b0;
      dout_ff       <= 1'b1;
      rdStrobe_ff   <= 1'b1;
      doneOe_ff     <= 1'b1;
      confOn_ff     <= 1'b1;
      confOff_ff    <= 1'b0;
      addrOe_ff     <= 1'b0;
      clkOe_ff      <= 1'b0;
      userClear_ff  <= 1'b0;
      userActive_ff <= 1'b0;
      prevClk_ff    <= 1'b0;
      prevWr_ff     <= 1'b0;
      prevTrig_ff   <= 1'b0;
      prevRst_ff    <= 1'b0;
    end else begin
      prevClk_ff  <= sClk;
      prevWr_ff   <= sWr;
      prevTrig_ff <= sModeZero;
      prevRst_ff  <= sRst;

      // Pin roles follow the phase one cycle later
      confOn_ff     <= (state_ff != `GACP_ST_USER);
      // Drops with the line, so done never shows high while pulled low
      confOff_ff    <= (state_ff == `GACP_ST_USER) & sDone;
      addrOe_ff     <= inLoad & isPar;
      clkOe_ff      <= runGen;
      rbOe_ff       <= (state_ff == `GACP_ST_USER);
      userActive_ff <= (state_ff == `GACP_ST_USER);
      userClear_ff  <= (state_ff == `GACP_ST_USER) & ~sRst;

      // Parallel fetch: address moves only while strobe is high
      if (inLoad && isPar && genRise) begin
        case (phase_ff)
          `GACP_PH_ADDR: begin
            rdStrobe_ff <= 1'b0;
            phase_ff    <= `GACP_PH_READ;
          end
          `GACP_PH_READ: begin
            byte_ff     <= sData;
            rdStrobe_ff <= 1'b1;
            bitIdx_ff   <= 3'h0;
            phase_ff    <= `GACP_PH_SHIFT;
          end
          `GACP_PH_SHIFT: begin
            bitIdx_ff <= bitIdx_ff + 3'h1;
            if (bitIdx_ff == 3'h7) begin
              phase_ff <= `GACP_PH_ADDR;
              if (mode_ff == `GACP_MODE_MSTHI)
                addr_ff <= addr_ff - 16'h0001;
              else
                addr_ff <= addr_ff + 16'h0001;
            end
          end
          default: phase_ff <= `GACP_PH_ADDR;
        endcase
      end else if (inLoad && (mode_ff == `GACP_MODE_MSTSER)) begin
        // PROM clock rises mid-cycle so data is settled at our edge
        rdStrobe_ff <= ~genClk_ff;
      end

      case (state_ff)
        `GACP_ST_RESET: begin
          if (rstRise) begin
            mode_ff     <= nxt_mode;
            state_ff    <= `GACP_ST_CONFIG;
            bitCnt_ff   <= 16'h0000;
            phase_ff    <= `GACP_PH_ADDR;
            rdStrobe_ff <= 1'b1;
            dout_ff     <= 1'b1;
            doneOe_ff   <= 1'b1;
            if (nxt_mode == `GACP_MODE_MSTHI)
              addr_ff <= `GACP_ADDR_HIGH;
            else
              addr_ff <= `GACP_ADDR_LOW;
          end
        end
        `GACP_ST_CONFIG: begin
          if (nxt_bitValid) begin
            bitCnt_ff <= bitCnt_ff + 16'h0001;
            snap_ff   <= {snap_ff[14:0], nxt_bitVal};
            if (lastBit) begin
              state_ff  <= `GACP_ST_WAIT;
              doneOe_ff <= 1'b0;
            end
          end
        end
        `GACP_ST_WAIT: begin
          // Own load done; pass later bits down the chain
          if (nxt_bitValid)
            dout_ff <= nxt_bitVal;
          if (sDone) begin
            state_ff    <= `GACP_ST_USER;
            rdStrobe_ff <= 1'b1;
          end
        end
        `GACP_ST_USER: begin
          if (trigRise)
            rbShift_ff <= snap_ff;
          else if (clkRise) begin
            rbOut_ff   <= rbShift_ff[15];
            rbShift_ff <= {rbShift_ff[14:0], 1'b0};
          end
          // Line pulled low from outside asks for a fresh load
          if (!sDone) begin
            state_ff    <= `GACP_ST_CONFIG;
            bitCnt_ff   <= 16'h0000;
            phase_ff    <= `GACP_PH_ADDR;
            dout_ff     <= 1'b1;
            doneOe_ff   <= 1'b1;
            if (mode_ff == `GACP_MODE_MSTHI)
              addr_ff <= `GACP_ADDR_HIGH;
            else
              addr_ff <= `GACP_ADDR_LOW;
          end
        end
        default: state_ff <= `GACP_ST_RESET;
      endcase

      // Reset pin aborts any load, but not user operation
      if (!sRst && (state_ff != `GACP_ST_USER)) begin
        state_ff    <= `GACP_ST_RESET;
        doneOe_ff   <= 1'b1;
        rdStrobe_ff <= 1'b1;
      end
    end
  end

  // ********************
  // Outputs
  // ********************
  assign modeSelectOneOut        = rbOut_ff;
  assign modeSelectOneOe         = rbOe_ff;
  assign configurationClockOut   = genClk_ff;
  assign configurationClockOe    = clkOe_ff;
  assign serialDataOut           = dout_ff;
  assign readStrobeN             = rdStrobe_ff;
  assign doneOut                 = confOff_ff;
  assign doneOe                  = doneOe_ff;
  assign highWhileConfiguringOut = confOn_ff;
  assign highWhileConfiguringOe  = confOn_ff;
  assign lowWhileConfiguringOut  = confOff_ff;
  assign lowWhileConfiguringOe   = confOn_ff;
  assign pullUpEn                = confOn_ff;
  assign promAddressBus          = addr_ff;
  assign promAddressOe           = addrOe_ff;
  assign userClear               = userClear_ff;
  assign userActive              = userActive_ff;

endmodule

`default_nettype wire

/* File: verif/gacp_config_port_chk.sv */
// Pin level assertions of the configuration port
`timescale 1ns/1ps
`default_nettype none
module gacp_config_port_chk (
  input wire logic        clk_sys,                 // System clock
  input wire logic        nrst,                    // Reset, active low
  input wire logic        modeSelectOneOe,         // Readback enable
  input wire logic        configurationClockOe,    // Clock pin enable
  input wire logic        readStrobeN,             // Read strobe
  input wire logic        doneOut,                 // Done value
  input wire logic        doneOe,                  // Done pull-down
  input wire logic        highWhileConfiguringOut, // High level pin
  input wire logic        lowWhileConfiguringOut,  // Low level pin
  input wire logic        pullUpEn,                // Pull-ups
  input wire logic [15:0] promAddressBus,          // Address
  input wire logic        promAddressOe,           // Address enable
  input wire logic        userClear,               // User clear
  input wire logic        userActive               // User mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_levels;
    !userActive |-> highWhileConfiguringOut && !lowWhileConfiguringOut;
  endproperty
  a_levels: assert property (p_levels) else $error("level pins wrong");
  property p_pulls;
    pullUpEn == !userActive;
  endproperty
  a_pulls: assert property (p_pulls) else $error("pull-ups wrong");
  property p_done_drive;
    doneOe |-> !doneOut;
  endproperty
  a_done_drive: assert property (p_done_drive) else $error("done not low");
  property p_user_entry;
    $rose(userActive) |-> !doneOe;
  endproperty
  a_user_entry: assert property (p_user_entry) else $error("user with done low");
  property p_user_pins;
    userActive && $past(userActive) |-> modeSelectOneOe && !configurationClockOe && !promAddressOe;
  endproperty
  a_user_pins: assert property (p_user_pins) else $error("user pins wrong");
  property p_clear;
    userClear |-> userActive;
  endproperty
  a_clear: assert property (p_clear) else $error("clear outside user");
  // Stepping is one address at a time and only while the strobe is high
  property p_step;
    promAddressOe && $past(promAddressOe) && promAddressBus != $past(promAddressBus) |->
      readStrobeN && (promAddressBus == $past(promAddressBus) + 16'h1 ||
                      promAddressBus == $past(promAddressBus) - 16'h1);
  endproperty
  a_step: assert property (p_step) else $error("address step wrong");
  property p_strobe;
    promAddressOe && $fell(readStrobeN) |-> !readStrobeN [*7] ##[1:2] readStrobeN;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe low time wrong");
endmodule
bind gacp_config_port gacp_config_port_chk i_gacp_config_port_chk (.*);
`default_nettype wire

/* File: verif/gacp_prom_model.sv */
// Byte-wide memory, host data line and wired done line
`timescale 1ns/1ps
`default_nettype none
module gacp_prom_model (
  input  wire logic [15:0] promAddressBus, // Address from the port
  input  wire logic        doneOe,         // Port pulls done low
  input  wire logic        doneOut,        // Port done value
  input  wire logic        holdLow,        // Chained device still loading
  input  wire logic        tbDin,          // Serial bit from the host
  input  wire logic        parMode,        // Byte-wide memory attached
  output logic      [7:0]  promDataBus,    // Data pins
  output logic             doneIn          // Wired done level
);
  logic [7:0] romByte;
  assign romByte = promAddressBus[7:0] ^ promAddressBus[15:8] ^ 8'h5A;
  // Memory selected by the done line; deselected it must not look valid
  always_comb begin
    if (!parMode)
      promDataBus = {7'h2A, tbDin};
    else if (!doneIn)
      promDataBus = romByte;
    else
      promDataBus = ~romByte;
  end
  assign doneIn = !((doneOe && !doneOut) || holdLow);
endmodule
`default_nettype wire

/* File: verif/gacp_config_port_test.sv */
// Bench: loads the port in slave, peripheral and both parallel master modes and compares with a model
`timescale 1ns/1ps
`default_nettype none
module gacp_config_port_test;
  logic        clk_sys = 1'b0, nrst = 1'b0, resetPinN = 1'b0;
  logic        modeSelectZeroIn = 1'b0, modeSelectOneIn = 1'b0, modeSelectTwoIn = 1'b0;
  logic        configurationClockIn = 1'b1, writeStrobeN = 1'b1, tbDin = 1'b0;
  logic        chipSelectLowAN = 1'b0, chipSelectLowBN = 1'b0, chipSelectHigh = 1'b1;
  logic        holdLow = 1'b0, parMode = 1'b0;
  logic [15:0] lfsr = 16'h92DF;
  wire  [15:0] promAddressBus;
  wire  [7:0]  promDataBus;
  wire         doneIn, modeSelectOneOut, modeSelectOneOe, configurationClockOut;
  wire         configurationClockOe, serialDataOut, readStrobeN, doneOut, doneOe;
  wire         highWhileConfiguringOut, highWhileConfiguringOe, lowWhileConfiguringOut;
  wire         lowWhileConfiguringOe, pullUpEn, promAddressOe, userClear, userActive;
  int          badCount = 0, nCompared = 0, cyc = 0, i;
  bit          b, q[$];
  gacp_config_port i_gacp_config_port (.*);
  gacp_prom_model  i_gacp_prom_model (.*);
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 50000) begin
      badCount++;
      giveVerdict();
    end
  end
  // ********************
  // Helpers
  // ********************
  function automatic bit rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[0];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #2;
  endtask
  task automatic startMode(input logic [2:0] m);
    tick();
    nrst = 1'b0;
    resetPinN = 1'b0;
    {modeSelectZeroIn, modeSelectOneIn, modeSelectTwoIn} = m;
    repeat (4) tick();
    nrst = 1'b1;
    repeat (4) tick();
    resetPinN = 1'b1;
    repeat (10) tick();
  endtask
  // Link clock of 320 ns, low first; rise lands before the fourth system edge
  task automatic pulseBit(input bit d, input bit wr);
    tbDin = d;
    if (wr) writeStrobeN = 1'b0; else configurationClockIn = 1'b0;
    #150;
    if (wr) writeStrobeN = 1'b1; else configurationClockIn = 1'b1;
    #170;
  endtask
  task automatic waitUser();
    int j;
    for (j = 0; j < 60 && userActive !== 1'b1; j++) tick();
    chk(userActive, 1'h1);
  endtask
  task automatic master(input logic [2:0] m, input logic [15:0] a0, input logic [15:0] st);
    int k, n;
    logic [15:0] ea;
    logic [7:0]  eb;
    parMode = 1'b1;
    holdLow = 1'b1;
    startMode(m);
    chk(configurationClockOe, 1'h1);
    for (k = 0; k < 130; k++) begin
      for (n = 0; n < 200 && readStrobeN !== 1'b0; n++) tick();
      chk(promAddressBus, a0 + st * k);
      for (n = 0; n < 200 && readStrobeN !== 1'b1; n++) tick();
      if (k == 128) chk(doneOe, 1'h0);
      if (k == 129) begin
        // Chained byte, fetched while the line is held, leaves bit zero first
        ea = 16'(a0 + st * k);
        eb = ea[7:0] ^ ea[15:8] ^ 8'h5A;
        for (n = 0; n < 8; n++) begin
          @(posedge configurationClockOut);
          #2;
          chk(serialDataOut, eb[n]);
        end
      end
    end
    holdLow = 1'b0;
    waitUser();
    chk(promAddressOe, 1'h0);
    parMode = 1'b0;
  endtask
  task automatic giveVerdict();
    $display("Compared %0d, errors %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ********************
  // Scenarios
  // ********************
  initial begin
    startMode(3'h0);
    chk(configurationClockOe, 1'h1);
    for (i = 0; i < 16; i++) begin
      b = configurationClockOut;
      tick();
      chk(readStrobeN, !b);
    end
    resetPinN = 1'b0;
    repeat (8) tick();
    chk(configurationClockOe, 1'h0);
    chk(readStrobeN, 1'h1);
    startMode(3'h7);
    chk(configurationClockOe, 1'h0);
    for (i = 0; i < 1024; i++) begin
      b = rnd();
      q.push_back(b);
      if (q.size() > 16) void'(q.pop_front());
      chk(doneOe, 1'h1);
      pulseBit(b, 1'b0);
    end
    waitUser();
    chk(pullUpEn, 1'h0);
    chk(highWhileConfiguringOe, 1'h0);
    chk(lowWhileConfiguringOe, 1'h0);
    resetPinN = 1'b0;
    repeat (8) tick();
    chk(userClear, 1'h1);
    resetPinN = 1'b1;
    modeSelectZeroIn = 1'b0;
    repeat (8) tick();
    chk(userActive, 1'h1);
    modeSelectZeroIn = 1'b1;
    repeat (8) tick();
    for (i = 0; i < 16; i++) begin
      pulseBit(rnd(), 1'b0);
      chk(modeSelectOneOut, q[i]);
    end
    holdLow = 1'b1;
    startMode(3'h5);
    chk(configurationClockOe, 1'h1);
    for (i = 0; i < 1027; i++) begin
      if (i % 300 == 299) begin
        {chipSelectLowAN, chipSelectLowBN, chipSelectHigh} = 3'h1 ^ (3'h4 >> (i / 300));
        pulseBit(1'b1, 1'b1);
        {chipSelectLowAN, chipSelectLowBN, chipSelectHigh} = 3'h1;
      end
      chk(doneOe, i < 1024);
      b = rnd();
      pulseBit(b, 1'b1);
      if (i > 1023) chk(serialDataOut, b);
    end
    holdLow = 1'b0;
    waitUser();
    master(3'h1, 16'h0000, 16'h0001);
    master(3'h3, 16'hFFFF, 16'hFFFF);
    giveVerdict();
  end
endmodule
`default_nettype wire
